// ### shared/fault_history_pkg.sv
`default_nettype none
package fault_history_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int BANNER_MS = 1000;
	localparam int BANNER_CYC = CLK_HZ / 1000 * BANNER_MS;
	localparam int ALT_MS = 500;
	localparam int ALT_CYC = CLK_HZ / 1000 * ALT_MS;
	localparam int NUM_RECORDS = 4;
	localparam int NUM_ENTRIES = 4;
	localparam int VAL_W = 16;
	localparam int IDX_W = 2;
	localparam logic [VAL_W-1:0] NONE_VALUE = 16'h0000;
	localparam logic [VAL_W-1:0] EMPTY_VALUE = 16'hFFFF;
	localparam logic [VAL_W-1:0] ESTOP_CODE = 16'h00E5;
	localparam logic [VAL_W-1:0] ESTOP_SECONDARY = 16'h0000;
	localparam logic [7:0] HISTORY_ENTRY_PARAM = 8'h20;
	localparam logic [IDX_W-1:0] ENTRY_PRIMARY = 2'h0;
	localparam logic [IDX_W-1:0] ENTRY_SECONDARY = 2'h1;
	localparam logic [IDX_W-1:0] ENTRY_FREQ = 2'h2;
	localparam logic [IDX_W-1:0] ENTRY_CURRENT = 2'h3;
	localparam logic [1:0] SHOW_VALUE = 2'h0;
	localparam logic [1:0] SHOW_INDEX = 2'h1;
	localparam logic [1:0] SHOW_BANNER = 2'h2;
	localparam logic [1:0] SHOW_EMPTY = 2'h3;
	typedef enum logic [1:0] {ST_MONITOR, ST_BANNER, ST_BROWSE} browse_state_t;
endpackage
`default_nettype wire

// ### hdl/fault_history_recorder.sv
`default_nettype none
module fault_history_recorder
	import fault_history_pkg::*;
#(
	parameter int BANNER_LEN = fault_history_pkg::BANNER_CYC, // Banner cycles
	parameter int ALT_LEN = fault_history_pkg::ALT_CYC // Alternation cycles
)
(
	input wire logic core_clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [7:0] monitor_param_sel, // Selected monitor parameter
	input wire logic set_key, // Set key pulse
	input wire logic mode_key, // Mode key pulse
	input wire logic digit_select_key, // Step to next record
	input wire logic knob_up, // Knob step up
	input wire logic knob_down, // Knob step down
	input wire logic history_clear_param, // Clear strobe, one = clear
	input wire logic fault_event, // Drive fault pulse
	input wire logic [fault_history_pkg::VAL_W-1:0] fault_primary, // Code
	input wire logic [fault_history_pkg::VAL_W-1:0] fault_secondary, // Code
	input wire logic [fault_history_pkg::VAL_W-1:0] out_freq, // Output freq
	input wire logic [fault_history_pkg::VAL_W-1:0] out_current, // Current
	input wire logic fault_reset_input, // Fault reset pin
	input wire logic emergency_stop_input, // Estop pin
	input wire logic estop_fault_select, // Treat estop as fault
	output logic browse_active, // In history browsing
	output logic [1:0] display_kind, // Banner, index, value or empty
	output logic [fault_history_pkg::IDX_W-1:0] disp_record, // Record index
	output logic [fault_history_pkg::IDX_W-1:0] disp_entry, // Entry index
	output logic [fault_history_pkg::VAL_W-1:0] display_value, // Value
	output logic fault_indicator, // Fault lamp
	output logic fault_relay_no, // NO contact closed
	output logic fault_relay_nc, // NC contact closed
	output logic run_permit // Operation permitted
);
	////////////////////////////////////////////////////////////////////
	logic rst_s1_reg, rst_s2_reg;
	logic rst_i_n;
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	assign rst_i_n = rst_s2_reg;

	// Pin inputs from the terminal block are asynchronous
	logic [2:0] pin_s1_reg, pin_s2_reg;
	always_ff @(posedge core_clk or negedge rst_i_n)
		if (!rst_i_n)
		begin
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
		end
		else
		begin
			pin_s1_reg <= {fault_reset_input, emergency_stop_input,
				estop_fault_select};
			pin_s2_reg <= pin_s1_reg;
		end
	logic reset_pin, estop_pin, estop_sel;
	assign {reset_pin, estop_pin, estop_sel} = pin_s2_reg;

	////////////////////////////////////////////////////////////////////
	// Fault capture; estop raises only on its rising edge
	logic estop_prev_reg;
	logic estop_fault, new_fault;
	logic [VAL_W-1:0] new_rec [NUM_ENTRIES];
	always_ff @(posedge core_clk or negedge rst_i_n)
		if (!rst_i_n)
			estop_prev_reg <= 1'b0;
		else
			estop_prev_reg <= estop_pin;
	assign estop_fault = estop_sel && estop_pin && !estop_prev_reg;
	assign new_fault = fault_event || estop_fault;
	always_comb
	begin
		new_rec[ENTRY_PRIMARY] = estop_fault ? ESTOP_CODE : fault_primary;
		new_rec[ENTRY_SECONDARY] = estop_fault ? ESTOP_SECONDARY
			: fault_secondary;
		new_rec[ENTRY_FREQ] = out_freq;
		new_rec[ENTRY_CURRENT] = out_current;
	end

	logic fault_latch_reg;
	// A new fault wins over a simultaneous reset
	always_ff @(posedge core_clk or negedge rst_i_n)
		if (!rst_i_n)
			fault_latch_reg <= 1'b0;
		else if (new_fault)
			fault_latch_reg <= 1'b1;
		else if (reset_pin)
			fault_latch_reg <= 1'b0;

	always_ff @(posedge core_clk or negedge rst_i_n)
		if (!rst_i_n)
		begin
			fault_indicator <= 1'b0;
			fault_relay_no <= 1'b0;
			fault_relay_nc <= 1'b1;
			run_permit <= 1'b1;
		end
		else
		begin
			fault_indicator <= fault_latch_reg;
			fault_relay_no <= fault_latch_reg;
			fault_relay_nc <= !fault_latch_reg;
			run_permit <= !fault_latch_reg;
		end

	////////////////////////////////////////////////////////////////////
	logic [VAL_W-1:0] hist_reg [NUM_RECORDS][NUM_ENTRIES];
	logic [NUM_RECORDS-1:0] filled_reg;
	// Fault beats clear so an arriving fault is never lost
	always_ff @(posedge core_clk or negedge rst_i_n)
		if (!rst_i_n)
			filled_reg <= '0;
		else if (new_fault)
			filled_reg <= {filled_reg[NUM_RECORDS-2:0], 1'b1};
		else if (history_clear_param)
			filled_reg <= '0;

	genvar gr, ge;
	generate
		for (gr = 0; gr < NUM_RECORDS; gr++)
		begin : g_rec
			for (ge = 0; ge < NUM_ENTRIES; ge++)
			begin : g_ent
				always_ff @(posedge core_clk or negedge rst_i_n)
					if (!rst_i_n)
						hist_reg[gr][ge] <= EMPTY_VALUE;
					else if (new_fault)
						hist_reg[gr][ge] <= (gr == 0) ? new_rec[ge]
							: hist_reg[(gr == 0) ? 0 : gr-1][ge];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	browse_state_t state_reg;
	// One timer serves both counts, so it is sized for the longer
	localparam int TMR_MAX = BANNER_LEN > ALT_LEN ? BANNER_LEN : ALT_LEN;
	logic [$clog2(TMR_MAX+1)-1:0] timer_reg;
	logic [IDX_W-1:0] rec_reg, ent_reg;
	logic phase_reg;
	logic entered, leaving, tick;
	assign entered = state_reg == ST_MONITOR && set_key
		&& monitor_param_sel == HISTORY_ENTRY_PARAM;
	assign leaving = state_reg != ST_MONITOR && mode_key;
	assign tick = state_reg == ST_BANNER
		? timer_reg == ($bits(timer_reg))'(BANNER_LEN - 1)
		: timer_reg == ($bits(timer_reg))'(ALT_LEN - 1);

	always_ff @(posedge core_clk or negedge rst_i_n)
		if (!rst_i_n)
			state_reg <= ST_MONITOR;
		else if (leaving)
			state_reg <= ST_MONITOR;
		else
			unique case (state_reg)
				ST_MONITOR: if (entered) state_reg <= ST_BANNER;
				ST_BANNER: if (tick) state_reg <= ST_BROWSE;
				ST_BROWSE: state_reg <= ST_BROWSE;
				default: state_reg <= ST_MONITOR;
			endcase

	always_ff @(posedge core_clk or negedge rst_i_n)
		if (!rst_i_n)
			timer_reg <= '0;
		// Keys restart the count only while browsing, so the banner
		// stands its full time unless the mode key ends it
		else if (state_reg == ST_MONITOR || tick)
			timer_reg <= '0;
		else if (state_reg == ST_BROWSE
			&& (knob_up || knob_down || digit_select_key))
			timer_reg <= '0;
		else
			timer_reg <= timer_reg + 1'b1;

	always_ff @(posedge core_clk or negedge rst_i_n)
		if (!rst_i_n)
			phase_reg <= 1'b0;
		else if (state_reg != ST_BROWSE)
			phase_reg <= 1'b0;
		else if (tick)
			phase_reg <= !phase_reg;

	// Knob walks entries and carries into records; digit key jumps records
	always_ff @(posedge core_clk or negedge rst_i_n)
		if (!rst_i_n)
		begin
			rec_reg <= '0;
			ent_reg <= '0;
		end
		else if (entered)
		begin
			rec_reg <= '0;
			ent_reg <= '0;
		end
		else if (state_reg == ST_BROWSE)
		begin
			if (digit_select_key)
			begin
				rec_reg <= rec_reg + 1'b1;
				ent_reg <= '0;
			end
			else if (knob_up)
				{rec_reg, ent_reg} <= {rec_reg, ent_reg} + 1'b1;
			else if (knob_down)
				{rec_reg, ent_reg} <= {rec_reg, ent_reg} - 1'b1;
		end

	always_ff @(posedge core_clk or negedge rst_i_n)
		if (!rst_i_n)
		begin
			browse_active <= 1'b0;
			display_kind <= SHOW_VALUE;
			disp_record <= '0;
			disp_entry <= '0;
			display_value <= '0;
		end
		else
		begin
			browse_active <= state_reg != ST_MONITOR;
			disp_record <= rec_reg;
			disp_entry <= ent_reg;
			display_value <= filled_reg[rec_reg]
				? hist_reg[rec_reg][ent_reg] : EMPTY_VALUE;
			if (state_reg == ST_BANNER)
				display_kind <= SHOW_BANNER;
			else if (!phase_reg)
				display_kind <= SHOW_INDEX;
			else if (!filled_reg[rec_reg])
				display_kind <= SHOW_EMPTY;
			else
				display_kind <= SHOW_VALUE;
		end
endmodule
`default_nettype wire

// ### verification/keypad_model.sv
`default_nettype none
module keypad_model
(
	input wire logic core_clk, // Clock
	input wire logic [2:0] key_req, // 1 set 2 mode 3 digit 4 up 5 dn 6 clr
	output logic set_key, // Pulse
	output logic mode_key, // Pulse
	output logic digit_select_key, // Pulse
	output logic knob_up, // Pulse
	output logic knob_down, // Pulse
	output logic history_clear_param // Pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	// Debounced keys give one clean pulse per press
	always_ff @(posedge core_clk)
	begin
		set_key <= key_req == 3'h1;
		mode_key <= key_req == 3'h2;
		digit_select_key <= key_req == 3'h3;
		knob_up <= key_req == 3'h4;
		knob_down <= key_req == 3'h5;
		history_clear_param <= key_req == 3'h6;
	end
endmodule
`default_nettype wire

// ### verification/fault_history_recorder_chk.sv
`default_nettype none
module fault_history_recorder_chk
	import fault_history_pkg::*;
#(
	parameter int BANNER_LEN = fault_history_pkg::BANNER_CYC // Banner cycles
)
(
	input wire logic core_clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic [7:0] monitor_param_sel, // Param
	input wire logic set_key, // Key
	input wire logic mode_key, // Key
	input wire logic fault_event, // Fault
	input wire logic fault_reset_input, // Pin
	input wire logic emergency_stop_input, // Pin
	input wire logic estop_fault_select, // Pin
	input wire logic browse_active, // Out
	input wire logic [1:0] display_kind, // Out
	input wire logic [fault_history_pkg::VAL_W-1:0] display_value, // Out
	input wire logic fault_indicator, // Out
	input wire logic fault_relay_no, // Out
	input wire logic fault_relay_nc, // Out
	input wire logic run_permit // Out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	a_relay_follow: assert property (
		fault_relay_no == fault_indicator && fault_relay_nc != fault_indicator)
		else $error("relay contacts disagree with lamp");
	a_permit_follow: assert property (
		run_permit != fault_indicator)
		else $error("run permit disagrees with lamp");
	a_fault_raise: assert property (
		fault_event |-> ##2 fault_indicator)
		else $error("fault not latched");
	a_estop_fault: assert property (
		$rose(emergency_stop_input) && estop_fault_select |-> ##4 fault_indicator)
		else $error("estop not raised as fault");
	a_reset_clears: assert property (
		(fault_reset_input && !fault_event && !emergency_stop_input)[*5]
		|-> !fault_indicator)
		else $error("fault reset ignored");
	a_banner_entry: assert property (
		set_key && monitor_param_sel == HISTORY_ENTRY_PARAM && !browse_active
		|-> ##2 browse_active && display_kind == SHOW_BANNER)
		else $error("no banner after entry");
	a_mode_exit: assert property (
		browse_active && mode_key |-> ##2 !browse_active)
		else $error("mode key did not leave browsing");
	a_empty_value: assert property (
		display_kind == SHOW_EMPTY |-> display_value == EMPTY_VALUE)
		else $error("empty slot shows a value");
	// Length of the current unbroken banner run
	int banner_run_reg;
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			banner_run_reg <= 0;
		else if (display_kind == SHOW_BANNER)
			banner_run_reg <= banner_run_reg + 1;
		else
			banner_run_reg <= 0;
	a_banner_length: assert property (
		$fell(display_kind == SHOW_BANNER) && browse_active
		|-> banner_run_reg == BANNER_LEN)
		else $error("banner shown for the wrong time");
	a_banner_bound: assert property (
		banner_run_reg <= BANNER_LEN)
		else $error("banner outlasts its time");
endmodule
`default_nettype wire

// ### verification/fault_history_recorder_bench.sv
`default_nettype none
module fault_history_recorder_bench
	import fault_history_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic fev; logic sel; logic est; logic exp;} row_t;
	row_t rows [3] = '{'{1, 0, 0, 1}, '{0, 1, 1, 1}, '{0, 0, 1, 0}};
	logic core_clk = 0, rst_n = 0, fault_event = 0, fault_reset_input = 0;
	logic emergency_stop_input = 0, estop_fault_select = 0;
	logic [7:0] monitor_param_sel = 8'h00;
	logic [2:0] key_req = 3'h0;
	logic [VAL_W-1:0] fault_primary = 0, fault_secondary = 0;
	logic [VAL_W-1:0] out_freq = 0, out_current = 0, display_value;
	logic set_key, mode_key, digit_select_key, knob_up, knob_down;
	logic history_clear_param, browse_active, fault_indicator;
	logic fault_relay_no, fault_relay_nc, run_permit;
	logic [1:0] display_kind, disp_record, disp_entry;
	int errors = 0, n_compared = 0;
	// Short counts so the walk through browsing fits a brief run
	localparam int BANNER_T = 20;
	localparam int ALT_T = 8;
	fault_history_recorder #(.BANNER_LEN(BANNER_T), .ALT_LEN(ALT_T))
		dut_u (.*);
	keypad_model keypad_u (.*);
	initial
		forever #50 core_clk = ~core_clk;
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task chk(input logic [15:0] got, exp);
	begin
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task press(input logic [2:0] k);
	begin
		key_req <= k;
		cyc(1);
		key_req <= 3'h0;
		cyc(1);
	end
	endtask
	task report_and_stop;
	begin
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	////////////////////////////////////////
	// Whole run is under two hundred cycles
	initial
	begin
		#500000;
		errors++;
		report_and_stop;
	end
	initial
	begin
		cyc(5);
		rst_n <= 1'b1;
		cyc(4);
		foreach (rows[i])
		begin
			fault_event <= rows[i].fev;
			estop_fault_select <= rows[i].sel;
			emergency_stop_input <= rows[i].est;
			fault_primary <= 16'(i + 1);
			cyc(1);
			fault_event <= 1'b0;
			cyc(6);
			chk(fault_indicator, rows[i].exp);
			chk(fault_relay_no, rows[i].exp);
			chk(fault_relay_nc, !rows[i].exp);
			chk(run_permit, !rows[i].exp);
			emergency_stop_input <= 1'b0;
			fault_reset_input <= 1'b1;
			cyc(6);
			fault_reset_input <= 1'b0;
			chk(fault_indicator, 1'b0);
			$display("row %0d done", i);
		end
		monitor_param_sel <= 8'h21;
		press(3'h1);
		cyc(4);
		chk(browse_active, 1'b0);
		monitor_param_sel <= HISTORY_ENTRY_PARAM;
		press(3'h1);
		cyc(4);
		chk(browse_active, 1'b1);
		chk(display_kind, SHOW_BANNER);
		press(3'h3);
		press(3'h4);
		press(3'h5);
		cyc(2);
		chk(display_kind, SHOW_BANNER);
		chk(disp_entry, 2'h0);
		press(3'h2);
		cyc(4);
		chk(browse_active, 1'b0);
		chk(display_value, ESTOP_CODE);
		press(3'h6);
		cyc(2);
		chk(display_value, EMPTY_VALUE);
		$display("browse done");
		fault_primary <= 16'h0011;
		fault_secondary <= 16'h0012;
		out_freq <= 16'h0013;
		out_current <= 16'h0014;
		fault_event <= 1'b1;
		cyc(1);
		fault_primary <= 16'h0021;
		fault_secondary <= 16'h0022;
		out_freq <= 16'h0023;
		out_current <= 16'h0024;
		cyc(1);
		fault_event <= 1'b0;
		cyc(3);
		chk(fault_indicator, 1'b1);
		chk(display_value, 16'h0021);
		press(3'h1);
		cyc(BANNER_T);
		chk(display_kind, SHOW_BANNER);
		cyc(2);
		chk(display_kind, SHOW_INDEX);
		chk(disp_record, 2'h0);
		cyc(ALT_T);
		chk(display_kind, SHOW_VALUE);
		chk(display_value, 16'h0021);
		press(3'h4);
		cyc(2);
		chk(display_value, 16'h0022);
		press(3'h4);
		press(3'h4);
		cyc(2);
		chk(disp_entry, 2'h3);
		chk(display_value, 16'h0024);
		press(3'h4);
		cyc(2);
		chk(disp_record, 2'h1);
		chk(display_value, 16'h0011);
		press(3'h5);
		cyc(2);
		chk(display_value, 16'h0024);
		press(3'h3);
		cyc(2);
		chk(display_value, 16'h0011);
		press(3'h3);
		cyc(2);
		chk(disp_record, 2'h2);
		chk(display_kind, SHOW_EMPTY);
		chk(display_value, EMPTY_VALUE);
		cyc(ALT_T);
		chk(display_kind, SHOW_INDEX);
		press(3'h2);
		cyc(4);
		chk(browse_active, 1'b0);
		$display("walk done");
		rst_n <= 1'b0;
		cyc(2);
		chk(fault_indicator, 1'b0);
		chk(fault_relay_nc, 1'b1);
		chk(run_permit, 1'b1);
		rst_n <= 1'b1;
		cyc(4);
		chk(fault_indicator, 1'b0);
		chk(browse_active, 1'b0);
		chk(display_value, EMPTY_VALUE);
		$display("reset done");
		report_and_stop;
	end
endmodule
bind fault_history_recorder fault_history_recorder_chk
	#(.BANNER_LEN(BANNER_LEN)) chk_u (.*);
`default_nettype wire
